// *** hdl/cmb_alloc.v ***
// Operation
// R1: Four fill buffers, four pending buffers and eight half-line write buffers exist.
// R2: A request whose needed buffers are not free stalls the core until they are.
// R3: A cache read miss takes one fill buffer.
// R4: A write-allocate write miss takes one fill buffer and one pending buffer.
// R5: A read or write to a line already being filled takes only a new pending buffer.
// R6: A non-cached read takes one fill buffer.
// R7: Each non-coalescing non-cached write takes a write buffer; coalesced store-multiple takes two.
// R8: An eviction takes one write buffer per dirty half line, a clean line none.
// R9: A prefetch takes one fill buffer plus zero to two write buffers for its eviction; the code takes no fill buffer if the line is already being filled.
// R10: Both data caches use 32 sets of 32-byte lines, so 1 KB strides share a set.
// R11: Dirty state and write-back work on 16-byte half lines.
// R12: A cache-hit load returns in three cycles; a dependent next use stalls two.
// R13: A prefetch that would fault or walk tables is dropped silently.
// R14: More than four outstanding loads and prefetches stall the core; the code stalls a request only when a needed fill, pending or write buffer is not free.
// R15: Fill buffers free on line return, write buffers free on bus acceptance.
`timescale 1ns/1ps
`include "cmb_defs.vh"

module cmb_alloc
#(
    parameter N_FILL = `CMB_FILL_BUFS,
    parameter N_PEND = `CMB_PEND_BUFS,
    parameter N_WR = `CMB_WR_BUFS,
    parameter AW = 32
)
(
    input wire sys_clk,
    input wire rst_b,
    input wire req_valid,
    input wire [2:0] req_op,
    input wire [AW-1:0] req_addr,
    input wire req_write_alloc,
    input wire req_coalesce,
    input wire [3:0] req_multi_count,
    input wire [1:0] req_dirty,
    input wire req_fault,
    output wire req_ready,
    output wire core_stall,
    output wire [4:0] req_set,
    output reg fill_issue,
    output reg [1:0] fill_issue_id,
    output reg [AW-1:0] fill_issue_addr,
    input wire fill_done,
    input wire [1:0] fill_done_id,
    output reg [3:0] wr_issue_count,
    input wire wr_accept,
    output reg [N_FILL-1:0] fill_busy,
    output reg [3:0] pend_used,
    output reg [3:0] wr_used,
    output reg prefetch_dropped,
    input wire load_hit_issue,
    input wire use_next,
    output wire load_result_valid,
    output wire load_use_stall
);

    // ----------------------------------------
    // Line matching
    // ----------------------------------------
    reg [AW-1:0] fill_line [0:N_FILL-1];
    reg [1:0] fill_pend [0:N_FILL-1];

    function [AW-1:0] line_of;
        input [AW-1:0] a;
        begin
            line_of = {a[AW-1:`CMB_LINE_LSB], {`CMB_LINE_LSB{1'b0}}};
        end
    endfunction

    function [3:0] ones2;
        input [1:0] v;
        begin
            ones2 = {3'h0, v[0]} + {3'h0, v[1]};
        end
    endfunction

    // R10: set index from line address
    assign req_set = req_addr[`CMB_LINE_LSB+`CMB_SET_BITS-1:`CMB_LINE_LSB];

    reg hit_fill;
    reg [1:0] hit_id;
    reg free_any;
    reg [1:0] free_id;
    integer i;

    always @*
    begin
        hit_fill = 1'b0;
        hit_id = 2'h0;
        free_any = 1'b0;
        free_id = 2'h0;
        for (i = N_FILL - 1; i >= 0; i = i - 1)
        begin
            if (fill_busy[i])
            begin
                // A fill retiring this cycle takes no new pending work, else its count would leak
                if (fill_line[i] == line_of(req_addr) && !(fill_done && fill_done_id == i[1:0]))
                begin
                    hit_fill = 1'b1;
                    hit_id = i[1:0];
                end
            end
            else
            begin
                free_any = 1'b1;
                free_id = i[1:0];
            end
        end
    end

    // ----------------------------------------
    // Resource demand per request
    // ----------------------------------------
    reg need_fill;
    reg need_pend;
    reg [3:0] need_wr;
    reg drop;

    always @*
    begin
        need_fill = 1'b0;
        need_pend = 1'b0;
        need_wr = 4'h0;
        drop = 1'b0;
        case (req_op)
            `CMB_OP_RD_MISS:
            begin
                // R5: read to a filling line
                if (hit_fill)
                    need_pend = 1'b1;
                // R3: read miss
                else
                    need_fill = 1'b1;
            end
            `CMB_OP_WR_MISS:
            begin
                // R5: write to a filling line
                if (hit_fill)
                    need_pend = 1'b1;
                // R4: write-allocate miss
                else if (req_write_alloc)
                begin
                    need_fill = 1'b1;
                    need_pend = 1'b1;
                end
                else
                    need_wr = 4'h1;
            end
            // R6: non-cached read
            `CMB_OP_NC_READ:
                need_fill = 1'b1;
            // R7: single non-cached write
            `CMB_OP_NC_WRITE:
                need_wr = 4'h1;
            // R7: store-multiple
            `CMB_OP_STORE_MULTIPLE_OP:
                need_wr = req_coalesce ? 4'h2 : req_multi_count;
            // R8: per dirty half line
            // R11: half-line write-back
            `CMB_OP_EVICT:
                need_wr = ones2(req_dirty);
            `CMB_OP_PREFETCH:
            begin
                // R13: faulting prefetch dropped
                if (req_fault)
                    drop = 1'b1;
                // R9: fill plus eviction writes
                else
                begin
                    need_fill = !hit_fill;
                    need_wr = ones2(req_dirty);
                end
            end
            default:
                need_fill = 1'b0;
        endcase
    end

    // R1: capacity limits
    // R14: fill exhaustion stalls
    wire fill_ok = !need_fill || free_any;
    wire pend_ok = !need_pend || (pend_used < N_PEND[3:0]);
    wire wr_ok = ({1'b0, wr_used} + {1'b0, need_wr}) <= N_WR[4:0];

    // R2: stall until resources free
    assign req_ready = drop || (fill_ok && pend_ok && wr_ok);
    assign core_stall = (req_valid && !req_ready) || load_use_stall;

    wire take = req_valid && req_ready && !drop;
    wire fill_take = take && need_fill;
    wire pend_take = take && need_pend;
    wire [1:0] pend_slot = need_fill ? free_id : hit_id;

    // ----------------------------------------
    // Buffer state
    // ----------------------------------------
    integer k;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fill_busy <= {N_FILL{1'b0}};
            pend_used <= 4'h0;
            wr_used <= 4'h0;
            fill_issue <= 1'b0;
            fill_issue_id <= 2'h0;
            fill_issue_addr <= {AW{1'b0}};
            wr_issue_count <= 4'h0;
            prefetch_dropped <= 1'b0;
            for (k = 0; k < N_FILL; k = k + 1)
            begin
                fill_line[k] <= {AW{1'b0}};
                fill_pend[k] <= 2'h0;
            end
        end
        else
        begin
            fill_issue <= fill_take;
            fill_issue_id <= free_id;
            fill_issue_addr <= line_of(req_addr);
            wr_issue_count <= take ? need_wr : 4'h0;
            prefetch_dropped <= req_valid && drop;
            // R15: fill freed on return
            if (fill_done && fill_busy[fill_done_id])
            begin
                fill_busy[fill_done_id] <= 1'b0;
                fill_pend[fill_done_id] <= 2'h0;
            end
            if (fill_take)
            begin
                fill_busy[free_id] <= 1'b1;
                fill_line[free_id] <= line_of(req_addr);
            end
            if (pend_take)
                fill_pend[pend_slot] <= fill_pend[pend_slot] + 2'h1;
            // Up to three pending entries on a fill retire with it, four wrap its 2-bit count to zero; a take and a retire in the same cycle both count
            pend_used <= pend_used + {3'h0, pend_take}
                - ((fill_done && fill_busy[fill_done_id]) ? {2'h0, fill_pend[fill_done_id]} : 4'h0);
            // R15: write freed on acceptance
            wr_used <= wr_used + (take ? need_wr : 4'h0) - {3'h0, wr_accept && (wr_used != 4'h0)};
        end
    end

    cmb_load_use u_load_use
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .load_hit_issue(load_hit_issue),
        .use_next(use_next),
        .result_valid(load_result_valid),
        .use_stall(load_use_stall)
    );

endmodule

// *** hdl/cmb_defs.vh ***
`ifndef CMB_DEFS_VH
`define CMB_DEFS_VH

// ----------------------------------------
// Resource counts
// ----------------------------------------
`define CMB_FILL_BUFS 4
`define CMB_PEND_BUFS 4
`define CMB_WR_BUFS 8
`define CMB_HALF_LINE_BYTES 16

// ----------------------------------------
// Cache geometry
// ----------------------------------------
`define CMB_SETS 32
`define CMB_LINE_BYTES 32
`define CMB_OFS_BITS 5
`define CMB_SET_BITS 5
`define CMB_LINE_LSB 5

// ----------------------------------------
// Load-use timing
// ----------------------------------------
`define CMB_LOAD_LATENCY 3
`define CMB_LOAD_USE_STALL 2

// ----------------------------------------
// Request kinds
// ----------------------------------------
`define CMB_OP_RD_MISS 3'h0
`define CMB_OP_WR_MISS 3'h1
`define CMB_OP_NC_READ 3'h2
`define CMB_OP_NC_WRITE 3'h3
`define CMB_OP_EVICT 3'h4
`define CMB_OP_PREFETCH 3'h5
`define CMB_OP_STORE_MULTIPLE_OP 3'h6

`endif

// *** hdl/cmb_load_use.v ***
`timescale 1ns/1ps
`include "cmb_defs.vh"

// ----------------------------------------
// Load-use interlock for cache-hit loads
// ----------------------------------------
module cmb_load_use
(
    input wire sys_clk,
    input wire rst_b,
    input wire load_hit_issue,
    input wire use_next,
    output reg result_valid,
    output wire use_stall
);

    reg [1:0] age;
    reg busy;

    // Result appears LOAD_LATENCY cycles after issue
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            age <= 2'h0;
            busy <= 1'b0;
            result_valid <= 1'b0;
        end
        else
        begin
            result_valid <= 1'b0;
            if (load_hit_issue)
            begin
                age <= 2'h1;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                // R12: three cycle result
                if (age == (`CMB_LOAD_LATENCY - 1))
                begin
                    busy <= 1'b0;
                    result_valid <= 1'b1;
                    age <= 2'h0;
                end
                else
                begin
                    age <= age + 2'h1;
                end
            end
        end
    end

    // R12: dependent use stalls two cycles
    assign use_stall = use_next & busy;

endmodule

// *** dv/cmb_alloc_checker.sv ***
`timescale 1ns/1ps
module cmb_alloc_checker
#(
    parameter AW = 32
)
(
    input wire sys_clk,
    input wire rst_b,
    input wire req_valid,
    input wire [2:0] req_op,
    input wire [AW-1:0] req_addr,
    input wire req_ready,
    input wire core_stall,
    input wire [4:0] req_set,
    input wire req_fault,
    input wire [1:0] req_dirty,
    input wire fill_issue,
    input wire [3:0] fill_busy,
    input wire [3:0] pend_used,
    input wire [3:0] wr_used,
    input wire [3:0] wr_issue_count,
    input wire prefetch_dropped,
    input wire load_hit_issue,
    input wire use_next,
    input wire load_result_valid,
    input wire load_use_stall
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    chk_stall_refused: assert property (req_valid && !req_ready |-> core_stall)
        else $error("refused request without stall");
    chk_fill_full: assert property (req_valid && req_op == 3'h2 && &fill_busy |-> !req_ready)
        else $error("read taken with all fill buffers busy");
    chk_wr_full: assert property (req_valid && req_op == 3'h3 && wr_used == 4'h8 |-> !req_ready)
        else $error("write taken with all write buffers busy");
    chk_count_bound: assert property (wr_used <= 4'h8 && pend_used <= 4'h4)
        else $error("buffer count beyond capacity");
    chk_set_index: assert property (req_set == req_addr[9:5])
        else $error("set index wrong");
    chk_load_latency: assert property (load_hit_issue |-> ##3 load_result_valid)
        else $error("load result not three cycles after issue");
    chk_use_stall: assert property (load_hit_issue ##1 use_next |-> load_use_stall && core_stall)
        else $error("dependent use not stalled");
    chk_nc_fill: assert property (req_valid && req_ready && req_op == 3'h2 |=> fill_issue)
        else $error("non-cached read started no fill");
    chk_evict_count: assert property (req_valid && req_ready && req_op == 3'h4 |=>
        wr_issue_count == $past(req_dirty[0]) + $past(req_dirty[1]))
        else $error("eviction write buffer count wrong");
    chk_pf_drop: assert property (req_valid && req_ready && req_op == 3'h5 && req_fault |=>
        prefetch_dropped && !fill_issue)
        else $error("faulting prefetch not dropped");
    cover property (req_valid && core_stall);
    cover property (prefetch_dropped);
    cover property (wr_used == 4'h8);
endmodule
bind cmb_alloc cmb_alloc_checker #(.AW(AW)) chk (.*);

// *** dv/cmb_mem_model.sv ***
`timescale 1ns/1ps
module cmb_mem_model
(
    input wire sys_clk,
    input wire rst_b,
    input wire fill_issue,
    input wire [1:0] fill_issue_id,
    input wire [3:0] wr_used,
    input wire hold,
    output reg fill_done,
    output reg [1:0] fill_done_id,
    output reg wr_accept
);
    logic [1:0] q[$];
    int age;
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q.delete();
            age = 0;
            fill_done <= 1'b0;
            fill_done_id <= 2'h0;
            wr_accept <= 1'b0;
        end
        else
        begin
            fill_done <= 1'b0;
            fill_done_id <= ~fill_done_id;
            wr_accept <= !hold && wr_used != 4'h0 && !wr_accept;
            if (fill_issue)
                q.push_back(fill_issue_id);
            age = (q.size() != 0 && !hold) ? age + 1 : 0;
            if (age > 6)
            begin
                fill_done <= 1'b1;
                fill_done_id <= q.pop_front();
                age = 0;
            end
        end
    end
endmodule

// *** dv/cmb_alloc_tb.sv ***
`timescale 1ns/1ps
module cmb_alloc_tb;
    logic sys_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write_alloc = 1'b1, req_coalesce = 1'b0;
    logic req_fault = 1'b0, load_hit_issue = 1'b0, use_next = 1'b0, hold = 1'b0;
    logic [2:0] req_op = 3'h0;
    logic [31:0] req_addr = 32'h0;
    logic [3:0] req_multi_count = 4'h1;
    logic [1:0] req_dirty = 2'h0;
    wire req_ready, core_stall, fill_issue, fill_done, wr_accept, prefetch_dropped, load_result_valid, load_use_stall;
    wire [4:0] req_set;
    wire [1:0] fill_issue_id, fill_done_id;
    wire [31:0] fill_issue_addr;
    wire [3:0] wr_issue_count, fill_busy, pend_used, wr_used;
    int fail_count = 0, n_tests = 0;
    cmb_alloc dut (.*);
    cmb_mem_model mem (.*);
    always #2.5 sys_clk = ~sys_clk;
    task automatic check(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------
    // Request side: valid stays up after acceptance, so callers either send again or idle
    // ----------------------------------------
    task automatic put(input [2:0] op, input [31:0] a, input [1:0] d, input co, input f);
        req_op = op;
        req_addr = a;
        req_dirty = d;
        req_coalesce = co;
        req_fault = f;
        req_valid = 1'b1;
    endtask
    task automatic send(input [2:0] op, input [31:0] a, input [1:0] d, input co, input f);
        int n;
        n = 0;
        put(op, a, d, co, f);
        while (req_ready !== 1'b1 && n < 300)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        // A request never accepted is a hang, not a pass
        if (n == 300)
            fail_count++;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic idle();
        req_valid = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic drain();
        int n;
        n = 0;
        hold = 1'b0;
        while ((fill_busy | pend_used | wr_used) !== 4'h0 && n < 300)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check({fill_busy, pend_used, wr_used}, 12'h0);
    endtask
    task automatic t_fill();
        hold = 1'b1;
        for (int i = 0; i < 4; i++)
            send(3'h2, 32'h40 * i, 2'h0, 1'b0, 1'b0);
        put(3'h2, 32'h1000, 2'h0, 1'b0, 1'b0);
        @(posedge sys_clk);
        #1;
        check(fill_busy, 4'hf);
        check({req_ready, core_stall}, 2'h1);
        hold = 1'b0;
        send(3'h2, 32'h1000, 2'h0, 1'b0, 1'b0);
        check(fill_issue, 1'b1);
        check(fill_issue_addr, 32'h1000);
        idle();
        drain();
    endtask
    task automatic t_merge();
        hold = 1'b1;
        send(3'h0, 32'h2000, 2'h0, 1'b0, 1'b0);
        send(3'h0, 32'h2008, 2'h0, 1'b0, 1'b0);
        check({4'($countones(fill_busy)), pend_used}, 8'h11);
        send(3'h1, 32'h3000, 2'h0, 1'b0, 1'b0);
        check({4'($countones(fill_busy)), pend_used}, 8'h22);
        send(3'h1, 32'h3010, 2'h0, 1'b0, 1'b0);
        check({4'($countones(fill_busy)), pend_used}, 8'h23);
        req_write_alloc = 1'b0;
        send(3'h1, 32'h4000, 2'h0, 1'b0, 1'b0);
        check({wr_issue_count, 4'($countones(fill_busy)), pend_used}, 12'h123);
        req_write_alloc = 1'b1;
        idle();
        drain();
    endtask
    task automatic t_wr();
        hold = 1'b1;
        for (int i = 0; i < 8; i++)
            send(3'h3, 32'h8000 + 4 * i, 2'h0, 1'b0, 1'b0);
        put(3'h3, 32'h9000, 2'h0, 1'b0, 1'b0);
        @(posedge sys_clk);
        #1;
        check({wr_used, core_stall}, 5'h11);
        hold = 1'b0;
        send(3'h3, 32'h9000, 2'h0, 1'b0, 1'b0);
        idle();
        drain();
        req_multi_count = 4'h8;
        send(3'h6, 32'ha000, 2'h0, 1'b0, 1'b0);
        check(wr_issue_count, 4'h8);
        idle();
        drain();
        send(3'h6, 32'ha000, 2'h0, 1'b1, 1'b0);
        check(wr_issue_count, 4'h2);
        idle();
        drain();
    endtask
    task automatic t_evict_pf();
        for (int d = 0; d < 4; d++)
        begin
            send(3'h4, 32'hb000, d[1:0], 1'b0, 1'b0);
            check(wr_issue_count, d[0] + d[1]);
            idle();
        end
        send(3'h5, 32'h5060, 2'h3, 1'b0, 1'b1);
        check({prefetch_dropped, fill_issue, req_set}, 7'h43);
        idle();
        send(3'h5, 32'h5460, 2'h3, 1'b0, 1'b0);
        check({fill_issue, wr_issue_count, req_set}, 10'h243);
        idle();
        drain();
    endtask
    task automatic t_load();
        load_hit_issue = 1'b1;
        use_next = 1'b1;
        @(posedge sys_clk);
        #1;
        load_hit_issue = 1'b0;
        check({load_use_stall, core_stall}, 2'h3);
        @(posedge sys_clk);
        #1;
        check(load_use_stall, 1'b1);
        @(posedge sys_clk);
        #1;
        check(load_result_valid, 1'b1);
        use_next = 1'b0;
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        check({fill_busy, pend_used, wr_used}, 12'h0);
        t_fill();
        t_merge();
        t_wr();
        t_evict_pf();
        t_load();
        print_verdict();
    end
    initial
    begin
        #40000;
        fail_count++;
        print_verdict();
    end
endmodule
